// ### pin_state_pkg.sv
package pin_state_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int PORT_W = 16;

  // ****************************************
  // Values after reset and modes
  // ****************************************
  localparam logic [ADDR_W-1:0] ADDR_RESET_VALUE = 24'h000000;
  localparam logic [2:0]        MODE_SINGLE_CHIP = 3'h7;

  // ****************************************
  // Standby timing figures
  // ****************************************
  localparam int CLK_PERIOD_NS       = 10;
  localparam int RESET_LEAD_CYCLES   = 10;
  localparam int WAKE_RESET_LEAD_NS  = 100;
  localparam int WAKE_RESET_LEAD_CYC = (WAKE_RESET_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bus state of the access in flight
  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_FIRST,
    BUS_SECOND,
    BUS_THIRD,
    BUS_WAIT
  } bus_state_t;

  // Request from the internal bus controller
  typedef struct packed {
    bus_state_t              state;
    logic                    two_state_area;
    logic [ADDR_W-1:0]       addr;
    logic [DATA_W-1:0]       wdata;
    logic                    data_oe;
    logic                    addr_strobe;
    logic                    read_strobe;
    logic                    upper_write;
    logic                    lower_write;
  } bus_req_t;

  // Port pin request from the port logic
  typedef struct packed {
    logic [PORT_W-1:0]       out;
    logic [PORT_W-1:0]       dir;
    logic [PORT_W-1:0]       cs_sel;
    logic [PORT_W-1:0]       addr_sel;
  } port_req_t;

  // Pin drive group; enables are low while driving
  typedef struct packed {
    logic [ADDR_W-1:0]       addr;
    logic                    addr_oe_n;
    logic [DATA_W-1:0]       data;
    logic                    data_oe_n;
    logic                    addr_strobe_n;
    logic                    read_strobe_n;
    logic                    upper_byte_write_n;
    logic                    lower_byte_write_n;
    logic                    strobe_oe_n;
    logic [PORT_W-1:0]       port;
    logic [PORT_W-1:0]       port_oe_n;
  } pin_drive_t;

endpackage : pin_state_pkg

// ### pin_sync2.sv
// ****************************************
// Two flip-flop synchroniser, reset high
// ****************************************
module pin_sync2 #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  // Next values
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  // Two stages
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule // pin_sync2

// ### reset_standby_bus_pin_control.sv
// Behaviour
// R1: Reset during access makes all ports inputs
// R2: Reset drives strobes high, data floats
// R3: First/second state reset: address low half-state later
// R4: Reset input sampled on falling clock edge
// R5: Wait-state reset behaves like second state
// R6: Third-state reset holds address that state
// R7: Two-state area second state: hold address
// R8: Host asserts reset 10 cycles before standby
// R9: Standby without reset when RAM not kept
// R10: Host asserts reset 100 ns before wake
// R11: Single-chip mode never grants bus release
// R12: Keep state: inputs float, outputs hold
// R13: Chip selects high, upper address floats
// R14: Hardware standby floats every listed pin
module reset_standby_bus_pin_control (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic                   chip_init_request_n,
  input  wire logic                   deep_sleep_request_n,
  input  wire logic [2:0]             op_mode,
  input  wire logic                   onchip_ram_enable,
  input  wire logic                   soft_standby,
  input  wire logic                   release_request,
  input  wire pin_state_pkg::bus_req_t  bus_req,
  input  wire pin_state_pkg::port_req_t port_req,
  output pin_state_pkg::pin_drive_t   pins,
  output logic                        release_grant,
  output logic                        chip_in_reset,
  output logic                        ram_retained
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic init_sync;
  logic sleep_sync;

  pin_sync2 #(.RESET_VAL(1'b1)) u_init_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (chip_init_request_n),
    .sync_out (init_sync)
  );

  pin_sync2 #(.RESET_VAL(1'b1)) u_sleep_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (deep_sleep_request_n),
    .sync_out (sleep_sync)
  );

  // ****************************************
  // Falling-edge sample of the reset pin
  // ****************************************
  logic init_fall_reg;

  // Capture synchronised level at the fall
  always_ff @(negedge sys_clk) begin
    if (rst) begin
      init_fall_reg <= 1'b1;
    end else begin
      init_fall_reg <= init_sync; // R4
    end
  end

  // ****************************************
  // Reset and address hold sequence
  // ****************************************
  typedef enum logic [1:0] {
    SEQ_RUN,
    SEQ_HOLD,
    SEQ_ADDR_LOW
  } seq_t;

  seq_t                              seq_reg;
  seq_t                              seq_next;
  logic [pin_state_pkg::ADDR_W-1:0]  addr_hold_reg;
  logic [pin_state_pkg::ADDR_W-1:0]  addr_hold_next;
  logic                              in_reset;
  logic                              hold_case;

  // Which bus states keep the address to end of state
  always_comb begin
    hold_case = (bus_req.state == pin_state_pkg::BUS_THIRD) ||                  // R6
                (bus_req.state == pin_state_pkg::BUS_SECOND && bus_req.two_state_area); // R7
    in_reset  = !init_fall_reg;
  end

  // Sequence next values
  always_comb begin
    seq_next       = seq_reg;
    addr_hold_next = addr_hold_reg;
    case (seq_reg)
      SEQ_RUN: begin
        addr_hold_next = bus_req.addr;
        if (in_reset) begin
          // First, wait and three-state-area second states go low after half a state
          seq_next = hold_case ? SEQ_HOLD : SEQ_ADDR_LOW; // R3 R5
        end
      end
      SEQ_HOLD: begin
        seq_next = SEQ_ADDR_LOW; // R6 R7
      end
      SEQ_ADDR_LOW: begin
        if (!in_reset) begin
          seq_next = SEQ_RUN;
        end
      end
      default: begin
        seq_next = SEQ_RUN;
      end
    endcase
  end

  // Sequence registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seq_reg       <= SEQ_ADDR_LOW;
      addr_hold_reg <= pin_state_pkg::ADDR_RESET_VALUE;
    end else begin
      seq_reg       <= seq_next;
      addr_hold_reg <= addr_hold_next;
    end
  end

  // ****************************************
  // Keep latches for port outputs
  // ****************************************
  logic [pin_state_pkg::PORT_W-1:0] keep_reg;
  logic [pin_state_pkg::PORT_W-1:0] keep_next;
  logic                             released;
  logic                             keep_state;
  logic                             hw_standby;
  logic                             single_chip;
  logic                             sleep_prev_reg;
  logic                             sleep_prev_next;

  // Mode and state decode
  always_comb begin
    hw_standby  = !sleep_sync;
    single_chip = (op_mode == pin_state_pkg::MODE_SINGLE_CHIP);
    released    = release_request && !single_chip && !in_reset; // R11
    keep_state  = soft_standby || released;
    keep_next   = keep_state ? keep_reg : port_req.out; // R12
    sleep_prev_next = hw_standby; // Marks the first standby cycle
  end

  // Last driven port level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      keep_reg       <= '0;
      sleep_prev_reg <= 1'b0;
    end else begin
      keep_reg       <= keep_next;
      sleep_prev_reg <= sleep_prev_next;
    end
  end

  // ****************************************
  // Pin drive computation
  // ****************************************
  pin_state_pkg::pin_drive_t pins_reg;
  pin_state_pkg::pin_drive_t pins_next;
  logic                      grant_reg;
  logic                      grant_next;
  logic                      ram_keep_reg;
  logic                      ram_keep_next;

  // Resolve each pin group by priority
  always_comb begin
    pins_next                    = '0;
    pins_next.addr               = bus_req.addr;
    pins_next.addr_oe_n          = 1'b0;
    pins_next.data               = bus_req.wdata;
    pins_next.data_oe_n          = !bus_req.data_oe;
    pins_next.addr_strobe_n      = !bus_req.addr_strobe;
    pins_next.read_strobe_n      = !bus_req.read_strobe;
    pins_next.upper_byte_write_n = !bus_req.upper_write;
    pins_next.lower_byte_write_n = !bus_req.lower_write;
    pins_next.strobe_oe_n        = 1'b0;
    pins_next.port               = port_req.out;
    pins_next.port_oe_n          = ~port_req.dir;
    grant_next                   = released;
    ram_keep_next                = ram_keep_reg;
    if (hw_standby) begin
      // Everything floats
      pins_next.addr_oe_n   = 1'b1; // R14
      pins_next.data_oe_n   = 1'b1; // R14
      pins_next.strobe_oe_n = 1'b1; // R14
      pins_next.port_oe_n   = '1;   // R14
      // Strobe levels parked inactive behind the floating drivers
      pins_next.addr_strobe_n      = 1'b1; // R2
      pins_next.read_strobe_n      = 1'b1; // R2
      pins_next.upper_byte_write_n = 1'b1; // R2
      pins_next.lower_byte_write_n = 1'b1; // R2
      grant_next            = 1'b0;
      // Retention decided once at entry; the wake reset must not change it
      ram_keep_next         = sleep_prev_reg ? ram_keep_reg :
                              (onchip_ram_enable && in_reset); // R8 R9
    end else if (in_reset) begin
      pins_next.port_oe_n          = '1; // R1
      pins_next.data_oe_n          = 1'b1; // R2
      pins_next.addr_strobe_n      = 1'b1; // R2
      pins_next.read_strobe_n      = 1'b1; // R2
      pins_next.upper_byte_write_n = 1'b1; // R2
      pins_next.lower_byte_write_n = 1'b1; // R2
      grant_next                   = 1'b0;
      ram_keep_next                = 1'b0;
      if (seq_next == SEQ_ADDR_LOW) begin
        pins_next.addr = pin_state_pkg::ADDR_RESET_VALUE; // R3 R5
      end else begin
        pins_next.addr = addr_hold_reg; // R6 R7
      end
    end else if (keep_state) begin
      ram_keep_next = 1'b0;
      if (released) begin
        pins_next.addr_oe_n   = 1'b1;
        pins_next.data_oe_n   = 1'b1;
        pins_next.strobe_oe_n = 1'b1;
      end
      // Keep: inputs float, outputs hold; chip selects high, address floats
      for (int i = 0; i < pin_state_pkg::PORT_W; i++) begin
        pins_next.port[i]      = port_req.cs_sel[i] ? 1'b1 : keep_reg[i]; // R12 R13
        pins_next.port_oe_n[i] = port_req.addr_sel[i] ? 1'b1 :           // R13
                                 (port_req.cs_sel[i] ? 1'b0 : !port_req.dir[i]); // R12
      end
    end else begin
      ram_keep_next = 1'b0;
    end
  end

  // Output registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pins_reg                    <= '0;
      pins_reg.addr_oe_n          <= 1'b0;
      pins_reg.data_oe_n          <= 1'b1;
      pins_reg.addr_strobe_n      <= 1'b1;
      pins_reg.read_strobe_n      <= 1'b1;
      pins_reg.upper_byte_write_n <= 1'b1;
      pins_reg.lower_byte_write_n <= 1'b1;
      pins_reg.port_oe_n          <= '1;
      grant_reg                   <= 1'b0;
      ram_keep_reg                <= 1'b0;
    end else begin
      pins_reg     <= pins_next;
      grant_reg    <= grant_next;
      ram_keep_reg <= ram_keep_next;
    end
  end

  assign pins          = pins_reg;
  assign release_grant = grant_reg;
  assign ram_retained  = ram_keep_reg;

  // Reset indication
  logic rst_flag_reg;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rst_flag_reg <= 1'b1;
    end else begin
      rst_flag_reg <= in_reset;
    end
  end
  assign chip_in_reset = rst_flag_reg;

endmodule // reset_standby_bus_pin_control

// ### reset_standby_bus_pin_control_assertions.sv
module pin_ctl_checker (
  input wire logic                      sys_clk,
  input wire logic                      rst,
  input wire logic                      chip_init_request_n,
  input wire logic                      deep_sleep_request_n,
  input wire logic [2:0]                op_mode,
  input wire logic                      onchip_ram_enable,
  input wire logic                      soft_standby,
  input wire logic                      release_request,
  input wire pin_state_pkg::bus_req_t   bus_req,
  input wire pin_state_pkg::port_req_t  port_req,
  input wire pin_state_pkg::pin_drive_t pins,
  input wire logic                      release_grant,
  input wire logic                      chip_in_reset,
  input wire logic                      ram_retained
);
  // ****************************************
  // Pin state checks
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  no_grant_m7_a: assert property (
    op_mode == 3'h7 && $past(op_mode) == 3'h7 |-> !release_grant) else $error("grant in mode 7");
  ports_input_a: assert property (
    $fell(chip_init_request_n) |-> ##[1:6] &pins.port_oe_n) else $error("ports not input");
  strobes_high_a: assert property (
    $fell(chip_init_request_n) |-> ##[1:6] pins.addr_strobe_n && pins.read_strobe_n
    && pins.upper_byte_write_n && pins.lower_byte_write_n && pins.data_oe_n)
    else $error("strobes or data not idle");
  addr_low_a: assert property (
    $fell(chip_init_request_n) && bus_req.state == pin_state_pkg::BUS_FIRST
    |-> ##[1:6] pins.addr == '0 && !pins.addr_oe_n) else $error("address not low");
  wait_like_a: assert property (
    $fell(chip_init_request_n) && bus_req.state == pin_state_pkg::BUS_WAIT
    |-> ##[1:6] pins.addr == '0 && !pins.addr_oe_n) else $error("wait reset differs");
  hw_float_a: assert property (
    !deep_sleep_request_n [*5] |-> pins.addr_oe_n && pins.data_oe_n && pins.strobe_oe_n
    && &pins.port_oe_n) else $error("pins driven in standby");
  port_keep_a: assert property (
    soft_standby && $past(soft_standby) && $past(soft_standby, 2) && !chip_in_reset
    && !$past(chip_in_reset) && deep_sleep_request_n && $past(deep_sleep_request_n, 4)
    |-> $stable(pins.port) && $stable(pins.port_oe_n)) else $error("port not kept");
  cs_high_a: assert property (
    soft_standby && $past(soft_standby) && op_mode == 3'h3 && !chip_in_reset
    && deep_sleep_request_n && $past(deep_sleep_request_n, 4) && $stable(port_req)
    |-> (pins.port & port_req.cs_sel) == port_req.cs_sel
    && (pins.port_oe_n & port_req.cs_sel) == '0
    && (pins.port_oe_n & port_req.addr_sel) == port_req.addr_sel) else $error("cs pins wrong");
endmodule // pin_ctl_checker

bind reset_standby_bus_pin_control pin_ctl_checker u_chk (
  .sys_clk, .rst, .chip_init_request_n, .deep_sleep_request_n, .op_mode, .onchip_ram_enable,
  .soft_standby, .release_request, .bus_req, .port_req, .pins, .release_grant,
  .chip_in_reset, .ram_retained);

// ### host_ctrl_model.sv
module host_ctrl_model (
  input  wire logic sys_clk,
  output logic      chip_init_request_n,
  output logic      deep_sleep_request_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Reset and standby pin sequencing
  // ****************************************
  initial begin
    chip_init_request_n = 1'b1;
    deep_sleep_request_n = 1'b1;
  end
  // Reset pin level after a falling edge
  task automatic set_init(input logic v);
    @(negedge sys_clk);
    chip_init_request_n = v;
  endtask
  // Standby entry, reset leads only when RAM is kept
  task automatic sleep(input logic keep);
    if (keep) begin
      set_init(1'b0);
      repeat (pin_state_pkg::RESET_LEAD_CYCLES) @(negedge sys_clk);
    end
    deep_sleep_request_n = 1'b0;
    @(negedge sys_clk);
    chip_init_request_n = 1'b1;
  endtask
  // Wake, reset leads standby release
  task automatic wake();
    set_init(1'b0);
    repeat (pin_state_pkg::WAKE_RESET_LEAD_CYC) @(negedge sys_clk);
    deep_sleep_request_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    chip_init_request_n = 1'b1;
  endtask
endmodule // host_ctrl_model

// ### test_reset_standby_bus_pin_control.sv
module test_reset_standby_bus_pin_control;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Bench
  // ****************************************
  logic                       sys_clk;
  logic                       rst;
  logic                       chip_init_request_n;
  logic                       deep_sleep_request_n;
  logic [2:0]                 op_mode;
  logic                       onchip_ram_enable;
  logic                       soft_standby;
  logic                       release_request;
  pin_state_pkg::bus_req_t    bus_req;
  pin_state_pkg::port_req_t   port_req;
  pin_state_pkg::pin_drive_t  pins;
  logic                       release_grant;
  logic                       chip_in_reset;
  logic                       ram_retained;
  int                         n_fail;
  int                         compares;
  int                         cycles;

  reset_standby_bus_pin_control uut (.sys_clk, .rst, .chip_init_request_n,
    .deep_sleep_request_n, .op_mode, .onchip_ram_enable, .soft_standby, .release_request,
    .bus_req, .port_req, .pins, .release_grant, .chip_in_reset, .ram_retained);
  host_ctrl_model host (.sys_clk, .chip_init_request_n, .deep_sleep_request_n);

  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Compare and count
  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // Verdict
  task automatic test_done();
    if (n_fail == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_fail++;
      test_done();
    end
  end
  // Reset pin low in mid access
  task automatic t_bus_reset(input pin_state_pkg::bus_state_t st, input logic two,
                             input logic hold);
    bus_req = '{st, two, 24'h5a3c81, 16'hbeef, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    repeat (3) @(negedge sys_clk);
    check(pins.addr === 24'h5a3c81 && pins.addr_strobe_n === 1'b0, "no access");
    host.set_init(1'b0);
    for (int i = 0; i < 8 && pins.addr_strobe_n !== 1'b1; i++) @(negedge sys_clk);
    check(pins.read_strobe_n === 1'b1 && pins.upper_byte_write_n === 1'b1, "strobe");
    check(pins.lower_byte_write_n === 1'b1 && pins.data_oe_n === 1'b1, "data");
    check(pins.port_oe_n === 16'hffff, "ports");
    check(pins.addr === (hold ? 24'h5a3c81 : 24'h000000), "addr");
    check(pins.addr_oe_n === 1'b0, "addr float");
    check(chip_in_reset === 1'b1, "reset flag");
    @(negedge sys_clk);
    check(pins.addr === 24'h000000, "addr late");
    bus_req.state = pin_state_pkg::BUS_IDLE;
    host.set_init(1'b1);
    repeat (6) @(negedge sys_clk);
  endtask
  // Software standby keep and chip selects
  task automatic t_keep();
    soft_standby = 1'b1;
    repeat (3) @(negedge sys_clk);
    port_req.out = 16'h005a;
    repeat (3) @(negedge sys_clk);
    check((pins.port & 16'h00ff) === 16'h00a5, "keep out");
    check(pins.port_oe_n === 16'hfc00, "keep dir");
    check((pins.port & 16'h0300) === 16'h0300, "cs high");
    soft_standby = 1'b0;
    port_req.out = 16'h00a5;
  endtask
  // Bus release refused then granted
  task automatic t_release();
    op_mode = 3'h7;
    release_request = 1'b1;
    repeat (4) @(negedge sys_clk);
    check(release_grant === 1'b0, "grant m7");
    op_mode = 3'h3;
    for (int i = 0; i < 8 && release_grant !== 1'b1; i++) @(negedge sys_clk);
    check(release_grant === 1'b1, "no grant");
    release_request = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
  // Hardware standby entry and wake
  task automatic t_standby(input logic keep);
    onchip_ram_enable = keep;
    host.sleep(keep);
    repeat (4) @(negedge sys_clk);
    check(pins.addr_oe_n === 1'b1 && pins.data_oe_n === 1'b1, "bus float");
    check(pins.strobe_oe_n === 1'b1 && pins.port_oe_n === 16'hffff, "pin float");
    check(ram_retained === keep, "ram");
    host.wake();
    repeat (6) @(negedge sys_clk);
    check(chip_in_reset === 1'b0, "wake");
  endtask
  // Main sequence
  initial begin
    n_fail = 0;
    compares = 0;
    cycles = 0;
    rst = 1'b1;
    op_mode = 3'h3;
    onchip_ram_enable = 1'b0;
    soft_standby = 1'b0;
    release_request = 1'b0;
    bus_req = '0;
    port_req = '{16'h00a5, 16'h03ff, 16'h0300, 16'h0c00};
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_bus_reset(pin_state_pkg::BUS_FIRST, 1'b0, 1'b0);
    t_bus_reset(pin_state_pkg::BUS_SECOND, 1'b0, 1'b0);
    t_bus_reset(pin_state_pkg::BUS_WAIT, 1'b0, 1'b0);
    t_bus_reset(pin_state_pkg::BUS_THIRD, 1'b0, 1'b1);
    t_bus_reset(pin_state_pkg::BUS_SECOND, 1'b1, 1'b1);
    t_keep();
    t_release();
    t_standby(1'b1);
    t_standby(1'b0);
    test_done();
  end
endmodule // test_reset_standby_bus_pin_control
